// ---- pcrcs_pkg.sv ----
// Notes on behaviour
// - Control bit 7 enables the CRC engine
// - Control bit 6 runs or stops shifter
// - Busy bit 5 high while bits remain
// - Bit 4 appends zeros after data
// - Bit 1 picks LSB-first else MSB-first
// - Full bit 0 marks unconsumed input word
// - Widths bits 3-0 hold poly width minus one
// - Low input byte write loads shifter word
// - Running sum readable, writable, resets zero
// - Shifter contents readable, reset to zero
// - Taps for terms 15..1, bit0 reads one
// - Scanner enable bit 7 touches nothing else
// - Scan run cleared past end with no fetch pending, or when CRC stopped
// - Region bit 2 selects EEPROM or flash
// - Plain mode requests when CRC accepts
// - Gated mode also needs trigger asserted
// - Burst mode requests memory whenever no fetched word is pending
// - 22-bit address increments per fetch
// - Address writes ignored while scan runs
// - CRC done set on busy falling edge
// - Scan done set when passing end address
// - Clearing CRC enable clears scan run
package pcrcs_pkg;
  localparam logic [4:0] ADDR_CRC_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_CRC_WIDTHS = 5'h01;
  localparam logic [4:0] ADDR_INPUT_HIGH = 5'h02;
  localparam logic [4:0] ADDR_INPUT_LOW = 5'h03;
  localparam logic [4:0] ADDR_SUM_HIGH = 5'h04;
  localparam logic [4:0] ADDR_SUM_LOW = 5'h05;
  localparam logic [4:0] ADDR_SER_HIGH = 5'h06;
  localparam logic [4:0] ADDR_SER_LOW = 5'h07;
  localparam logic [4:0] ADDR_TAPS_HIGH = 5'h08;
  localparam logic [4:0] ADDR_TAPS_LOW = 5'h09;
  localparam logic [4:0] ADDR_SCAN_CONTROL = 5'h0A;
  localparam logic [4:0] ADDR_CUR_UPPER = 5'h0B;
  localparam logic [4:0] ADDR_CUR_HIGH = 5'h0C;
  localparam logic [4:0] ADDR_CUR_LOW = 5'h0D;
  localparam logic [4:0] ADDR_END_UPPER = 5'h0E;
  localparam logic [4:0] ADDR_END_HIGH = 5'h0F;
  localparam logic [4:0] ADDR_END_LOW = 5'h10;
  localparam logic [4:0] ADDR_EVENTS = 5'h11;
  localparam int CTL_ENABLE = 7;
  localparam int CTL_RUN = 6;
  localparam int CTL_BUSY = 5;
  localparam int CTL_AUGMENT = 4;
  localparam int CTL_LSB_FIRST = 1;
  localparam int CTL_FULL = 0;
  localparam int SCN_ENABLE = 7;
  localparam int SCN_TRIG_GATE = 6;
  localparam int SCN_RUN = 5;
  localparam int SCN_REGION = 2;
  localparam int SCN_BURST = 1;
  localparam int SCN_BUSY = 0;
  localparam int EVT_CRC_DONE = 0;
  localparam int EVT_SCAN_DONE = 1;
  localparam logic [7:0] WIDTHS_RESET = 8'h00;
  localparam logic [15:0] TAPS_RESET = 16'h0001;
  localparam logic [15:0] INPUT_RESET = 16'h0000;
  localparam logic [21:0] CUR_RESET = 22'h000000;
  localparam logic [21:0] END_RESET = 22'h3FFFFF;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } pcrcs_bus_s;
  typedef struct packed {
    logic req;
    logic region;
    logic [21:0] addr;
  } pcrcs_mreq_s;
  typedef struct packed {
    logic grant;
    logic [15:0] data;
  } pcrcs_mrsp_s;
endpackage : pcrcs_pkg

// ---- pcrcs_step.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcrcs_step (
  input wire logic [15:0] sum_in,
  input wire logic [15:0] poly,
  input wire logic [3:0] pwidth,
  input wire logic augment,
  input wire logic din,
  output logic [15:0] next_sum
);
  import pcrcs_pkg::*;
  logic top_bit;
  logic feedback;
  logic [15:0] raw;
  assign top_bit = sum_in[pwidth];
  // Augmented form shifts data in at the bottom
  assign feedback = augment ? top_bit : (top_bit ^ din);
  assign raw = {sum_in[14:0], augment & din} ^ (feedback ? poly : 16'h0000);
  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_mask
      assign next_sum[i] = (i <= int'(pwidth)) ? raw[i] : 1'b0;
    end
  endgenerate
endmodule : pcrcs_step
`default_nettype wire

// ---- pcrcs_top.sv ----
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pcrcs_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pcrcs_pkg::pcrcs_bus_s bus,
  output logic [7:0] rd_data,
  output pcrcs_pkg::pcrcs_mreq_s mem,
  input wire pcrcs_pkg::pcrcs_mrsp_s rsp,
  input wire logic scan_trigger
);
  import pcrcs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  logic crc_enable_bit;
  logic crc_run_bit;
  logic crc_busy;
  logic zero_augment_mode;
  logic lsb_first_mode;
  logic full;
  logic [3:0] data_width_minus_one;
  logic [3:0] poly_width_minus_one;
  logic [15:0] input_word;
  logic [15:0] running_sum;
  logic [15:0] shifter;
  logic [15:1] taps;
  logic [4:0] bit_cnt;
  logic [4:0] zero_cnt;
  logic seen;
  logic scan_enable;
  logic scan_trigger_gate;
  logic scan_run;
  logic memory_region_select;
  logic scan_burst_mode;
  logic scan_busy;
  logic [21:0] scan_current_address;
  logic [21:0] scan_end_address;
  logic [15:0] fetch_word;
  logic crc_done_flag;
  logic scan_done_flag;
  logic trig_meta;
  logic trig_sync;
  logic next_busy;
  logic next_scan_req;
  logic [15:0] next_sum;
  logic wr_ctl;
  logic wr_scan;
  logic wr_low;
  logic active;
  logic load_shifter;
  logic shifting;
  logic start_zeros;
  logic zeroing;
  logic feed_bit;
  logic past_end;
  logic take_grant;
  logic hand_over;
  logic [21:0] addr_inc;
  ////////////////////////////////////////////////////////////////////////////
  // Decode and datapath conditions
  assign wr_ctl = bus.wr && (bus.addr == ADDR_CRC_CONTROL);
  assign wr_scan = bus.wr && (bus.addr == ADDR_SCAN_CONTROL);
  assign wr_low = bus.wr && (bus.addr == ADDR_INPUT_LOW);
  assign active = crc_enable_bit && crc_run_bit;
  assign load_shifter = active && full && (bit_cnt == 5'h00) && (zero_cnt == 5'h00);
  assign shifting = active && (bit_cnt != 5'h00);
  assign start_zeros = active && zero_augment_mode && seen && !full
                       && (bit_cnt == 5'h00) && (zero_cnt == 5'h00);
  assign zeroing = active && (zero_cnt != 5'h00);
  assign feed_bit = zeroing ? 1'b0
                  : (lsb_first_mode ? shifter[0] : shifter[data_width_minus_one]);
  assign next_busy = full || (bit_cnt != 5'h00) || (zero_cnt != 5'h00)
                     || (zero_augment_mode && seen);
  assign past_end = scan_current_address > scan_end_address;
  assign addr_inc = scan_current_address + 22'h000001;
  assign take_grant = mem.req && rsp.grant;
  assign hand_over = scan_busy && !full && !wr_low;
  pcrcs_step u_step (
    .sum_in(running_sum),
    .poly({taps, 1'b1}),
    .pwidth(poly_width_minus_one),
    .augment(zero_augment_mode),
    .din(feed_bit),
    .next_sum(next_sum)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end else begin
      trig_meta <= scan_trigger;
      trig_sync <= trig_meta;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // CRC control and widths
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      crc_enable_bit <= 1'b0;
      crc_run_bit <= 1'b0;
      zero_augment_mode <= 1'b0;
      lsb_first_mode <= 1'b0;
      data_width_minus_one <= WIDTHS_RESET[7:4];
      poly_width_minus_one <= WIDTHS_RESET[3:0];
    end else begin
      if (wr_ctl) begin
        crc_enable_bit <= bus.wdata[CTL_ENABLE];
        crc_run_bit <= bus.wdata[CTL_RUN];
        zero_augment_mode <= bus.wdata[CTL_AUGMENT];
        lsb_first_mode <= bus.wdata[CTL_LSB_FIRST];
      end
      if (bus.wr && (bus.addr == ADDR_CRC_WIDTHS)) begin
        data_width_minus_one <= bus.wdata[7:4];
        poly_width_minus_one <= bus.wdata[3:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Input word and full flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      input_word <= INPUT_RESET;
      full <= 1'b0;
    end else begin
      if (bus.wr && (bus.addr == ADDR_INPUT_HIGH)) begin
        input_word[15:8] <= bus.wdata;
      end
      if (wr_low) begin
        input_word[7:0] <= bus.wdata;
        full <= 1'b1;
      end else if (hand_over) begin
        input_word <= fetch_word;
        full <= 1'b1;
      end else if (load_shifter) begin
        full <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Serial shifter and counters
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shifter <= 16'h0000;
      bit_cnt <= 5'h00;
      zero_cnt <= 5'h00;
      seen <= 1'b0;
    end else if (load_shifter) begin
      shifter <= input_word;
      bit_cnt <= {1'b0, data_width_minus_one} + 5'h01;
    end else if (shifting) begin
      shifter <= lsb_first_mode ? {1'b0, shifter[15:1]} : {shifter[14:0], 1'b0};
      bit_cnt <= bit_cnt - 5'h01;
      seen <= zero_augment_mode;
    end else if (start_zeros) begin
      zero_cnt <= {1'b0, poly_width_minus_one} + 5'h01;
      seen <= 1'b0;
    end else if (zeroing) begin
      zero_cnt <= zero_cnt - 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Running sum and taps
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      running_sum <= 16'h0000;
    end else if (bus.wr && (bus.addr == ADDR_SUM_HIGH)) begin
      running_sum[15:8] <= bus.wdata;
    end else if (bus.wr && (bus.addr == ADDR_SUM_LOW)) begin
      running_sum[7:0] <= bus.wdata;
    end else if (shifting || zeroing) begin
      running_sum <= next_sum;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      taps <= TAPS_RESET[15:1];
    end else if (bus.wr && (bus.addr == ADDR_TAPS_HIGH)) begin
      taps[15:8] <= bus.wdata;
    end else if (bus.wr && (bus.addr == ADDR_TAPS_LOW)) begin
      taps[7:1] <= bus.wdata[7:1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Busy tracking and done flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      crc_busy <= 1'b0;
    end else begin
      crc_busy <= next_busy;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      crc_done_flag <= 1'b0;
      scan_done_flag <= 1'b0;
    end else begin
      if (crc_busy && !next_busy) begin
        crc_done_flag <= 1'b1;
      end else if (bus.wr && (bus.addr == ADDR_EVENTS) && bus.wdata[EVT_CRC_DONE]) begin
        crc_done_flag <= 1'b0;
      end
      if (take_grant && (addr_inc > scan_end_address)) begin
        scan_done_flag <= 1'b1;
      end else if (bus.wr && (bus.addr == ADDR_EVENTS) && bus.wdata[EVT_SCAN_DONE]) begin
        scan_done_flag <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Scanner control
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scan_enable <= 1'b0;
      scan_trigger_gate <= 1'b0;
      memory_region_select <= 1'b0;
      scan_burst_mode <= 1'b0;
    end else if (wr_scan) begin
      scan_enable <= bus.wdata[SCN_ENABLE];
      scan_trigger_gate <= bus.wdata[SCN_TRIG_GATE];
      memory_region_select <= bus.wdata[SCN_REGION];
      scan_burst_mode <= bus.wdata[SCN_BURST];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scan_run <= 1'b0;
    end else if (wr_ctl && !bus.wdata[CTL_ENABLE]) begin
      scan_run <= 1'b0;
    end else if (!crc_enable_bit) begin
      scan_run <= 1'b0;
    end else if (!crc_run_bit || (wr_ctl && !bus.wdata[CTL_RUN])) begin
      scan_run <= 1'b0;
    end else if (past_end && !scan_busy && !take_grant) begin
      scan_run <= 1'b0;
    end else if (wr_scan) begin
      scan_run <= bus.wdata[SCN_RUN];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Scan addresses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scan_current_address <= CUR_RESET;
    end else if (take_grant) begin
      scan_current_address <= addr_inc;
    end else if (bus.wr && !scan_run) begin
      if (bus.addr == ADDR_CUR_UPPER) begin
        scan_current_address[21:16] <= bus.wdata[5:0];
      end
      if (bus.addr == ADDR_CUR_HIGH) begin
        scan_current_address[15:8] <= bus.wdata;
      end
      if (bus.addr == ADDR_CUR_LOW) begin
        scan_current_address[7:0] <= bus.wdata;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scan_end_address <= END_RESET;
    end else if (bus.wr && !scan_run) begin
      if (bus.addr == ADDR_END_UPPER) begin
        scan_end_address[21:16] <= bus.wdata[5:0];
      end
      if (bus.addr == ADDR_END_HIGH) begin
        scan_end_address[15:8] <= bus.wdata;
      end
      if (bus.addr == ADDR_END_LOW) begin
        scan_end_address[7:0] <= bus.wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Memory request and fetched word
  always_comb begin
    next_scan_req = 1'b0;
    if (scan_run && scan_enable && !scan_busy && !past_end && !take_grant) begin
      if (scan_burst_mode) begin
        next_scan_req = 1'b1;
      end else if (!full && !load_shifter) begin
        next_scan_req = !scan_trigger_gate || trig_sync;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mem <= '0;
    end else begin
      mem.req <= next_scan_req;
      mem.region <= memory_region_select;
      mem.addr <= take_grant ? addr_inc : scan_current_address;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scan_busy <= 1'b0;
      fetch_word <= INPUT_RESET;
    end else if (take_grant) begin
      scan_busy <= 1'b1;
      fetch_word <= rsp.data;
    end else if (hand_over) begin
      scan_busy <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CRC_CONTROL: rd_data <= {crc_enable_bit, crc_run_bit, crc_busy,
                                      zero_augment_mode, 2'b00, lsb_first_mode, full};
        ADDR_CRC_WIDTHS: rd_data <= {data_width_minus_one, poly_width_minus_one};
        ADDR_INPUT_HIGH: rd_data <= input_word[15:8];
        ADDR_INPUT_LOW: rd_data <= input_word[7:0];
        ADDR_SUM_HIGH: rd_data <= running_sum[15:8];
        ADDR_SUM_LOW: rd_data <= running_sum[7:0];
        ADDR_SER_HIGH: rd_data <= shifter[15:8];
        ADDR_SER_LOW: rd_data <= shifter[7:0];
        ADDR_TAPS_HIGH: rd_data <= taps[15:8];
        ADDR_TAPS_LOW: rd_data <= {taps[7:1], 1'b1};
        ADDR_SCAN_CONTROL: rd_data <= {scan_enable, scan_trigger_gate, scan_run, 2'b00,
                                       memory_region_select, scan_burst_mode, scan_busy};
        ADDR_CUR_UPPER: rd_data <= {2'b00, scan_current_address[21:16]};
        ADDR_CUR_HIGH: rd_data <= scan_current_address[15:8];
        ADDR_CUR_LOW: rd_data <= scan_current_address[7:0];
        ADDR_END_UPPER: rd_data <= {2'b00, scan_end_address[21:16]};
        ADDR_END_HIGH: rd_data <= scan_end_address[15:8];
        ADDR_END_LOW: rd_data <= scan_end_address[7:0];
        ADDR_EVENTS: rd_data <= {6'h00, scan_done_flag, crc_done_flag};
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule : pcrcs_top
`default_nettype wire

// ---- pcrcs_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcrcs_mem_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pcrcs_pkg::pcrcs_mreq_s mem,
  output pcrcs_pkg::pcrcs_mrsp_s rsp,
  input wire logic slow
);
  import pcrcs_pkg::*;
  logic [1:0] wait_cnt;
  ////////////////////////////////////////
  // Arbiter: one grant pulse per request, stalls model higher-priority traffic
  always_ff @(posedge clk_sys) begin
    rsp.grant <= 1'b0;
    rsp.data <= ~rsp.data;
    if (reset) begin
      wait_cnt <= 2'h0;
      rsp.data <= 16'h5AA5;
    end else if (mem.req && !rsp.grant) begin
      if (wait_cnt == 2'h0) begin
        rsp.grant <= 1'b1;
        rsp.data <= {mem.addr[7:0], ~mem.addr[7:0]} ^ {15'h0000, mem.region};
        wait_cnt <= slow ? 2'($urandom) : 2'h0;
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule : pcrcs_mem_model
`default_nettype wire

// ---- pcrcs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcrcs_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pcrcs_pkg::pcrcs_bus_s bus,
  input wire logic [7:0] rd_data,
  input wire pcrcs_pkg::pcrcs_mreq_s mem,
  input wire pcrcs_pkg::pcrcs_mrsp_s rsp,
  input wire logic scan_trigger
);
  import pcrcs_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  taps_bit0_a: assert property (bus.rd && bus.addr == ADDR_TAPS_LOW |=> rd_data[0])
    else $error("taps low bit0 not one");
  ctl_unused_a: assert property (bus.rd && bus.addr == ADDR_CRC_CONTROL |=> rd_data[3:2] == 2'h0)
    else $error("control unused bits not zero");
  addr_step_a: assert property (mem.req && rsp.grant |=> mem.addr == $past(mem.addr) + 22'h1)
    else $error("fetch address did not step");
  req_gap_a: assert property (mem.req && rsp.grant |=> !mem.req)
    else $error("request right after grant");
  addr_hold_a: assert property (mem.req && !rsp.grant |=> mem.addr == $past(mem.addr))
    else $error("fetch address moved while waiting");
  req_hold_a: assert property (mem.req && !rsp.grant && !bus.wr && !$past(bus.wr)
    && scan_trigger && $past(scan_trigger) && $past(scan_trigger, 2) |=> mem.req)
    else $error("request dropped before grant");
  region_copy_a: assert property (bus.wr && bus.addr == ADDR_SCAN_CONTROL
    ##1 !(bus.wr && bus.addr == ADDR_SCAN_CONTROL)
    |=> mem.region == $past(bus.wdata[SCN_REGION], 2))
    else $error("region output differs from control");
  stop_scan_a: assert property (bus.wr && bus.addr == ADDR_CRC_CONTROL && !bus.wdata[CTL_ENABLE]
    ##1 !bus.wr [*3] |-> !mem.req)
    else $error("request after crc disable");
  reset_quiet_a: assert property (disable iff (1'b0) reset
    |=> !mem.req && mem.addr == 22'h0 && rd_data == 8'h00)
    else $error("outputs not cleared by reset");
endmodule : pcrcs_chk
bind pcrcs_top pcrcs_chk u_chk (.clk_sys(clk_sys), .reset(reset), .bus(bus),
  .rd_data(rd_data), .mem(mem), .rsp(rsp), .scan_trigger(scan_trigger));
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pcrcs_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic scan_trigger = 1'b1;
  logic slow = 1'b0;
  logic trig_rand = 1'b0;
  pcrcs_bus_s bus = '0;
  logic [7:0] rd_data;
  pcrcs_mreq_s mem;
  pcrcs_mrsp_s rsp;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  int dl;
  int pl;
  logic [7:0] rv;
  logic [15:0] poly;
  logic [15:0] sum_exp;
  logic [15:0] w [2];
  logic [21:0] base;
  logic [21:0] nx;
  logic rg;
  always #4 clk_sys = ~clk_sys;
  pcrcs_top u_dut (.clk_sys(clk_sys), .reset(reset), .bus(bus), .rd_data(rd_data),
    .mem(mem), .rsp(rsp), .scan_trigger(scan_trigger));
  pcrcs_mem_model u_mem (.clk_sys(clk_sys), .reset(reset), .mem(mem), .rsp(rsp), .slow(slow));
  ////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    scan_trigger <= trig_rand ? 1'($urandom) : 1'b1;
    if (cycles == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys);
    bus <= '0;
    #1 d = rd_data;
  endtask : rd
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    rd(a, rv);
    chk(24'(rv), 24'(e));
  endtask : rchk
  task automatic poll(input logic [4:0] a, input int b, input logic v);
    int t;
    t = 0;
    do begin
      rd(a, rv);
      t++;
    end while (rv[b] !== v && t < 500);
    chk(24'(rv[b]), 24'(v));
  endtask : poll
  function automatic logic [15:0] step(logic [15:0] a, logic din, logic aug);
    logic fb;
    fb = a[pl] ^ (din & !aug);
    a = aug ? ((a << 1) | 16'(din)) : (a << 1);
    return (fb ? a ^ poly : a) & (16'hFFFF >> (15 - pl));
  endfunction : step
  function automatic logic [15:0] crc_word(logic [15:0] a, logic [15:0] d, logic aug, logic lsb);
    for (int i = 0; i <= dl; i++) begin
      a = step(a, d[lsb ? i : dl - i], aug);
    end
    return a;
  endfunction : crc_word
  function automatic logic [15:0] mdata(logic [21:0] a, logic r);
    return {a[7:0], ~a[7:0]} ^ {15'h0000, r};
  endfunction : mdata
  ////////////////////////////////////////
  initial begin
    rv = 8'($urandom(32'h76AA));
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 20; a++) begin
      if (a == 2 || a == 3) continue;
      rchk(5'(a), a == 9 ? 8'h01 : a == 14 ? 8'h3F : a == 15 || a == 16 ? 8'hFF : 8'h00);
    end
    $display("reset values done");
    wr(ADDR_SER_HIGH, 8'h5A);
    rchk(ADDR_SER_HIGH, 8'h00);
    wr(ADDR_TAPS_LOW, 8'h00);
    rchk(ADDR_TAPS_LOW, 8'h01);
    wr(ADDR_CRC_WIDTHS, 8'hA7);
    rchk(ADDR_CRC_WIDTHS, 8'hA7);
    wr(ADDR_CRC_CONTROL, 8'hCE);
    rchk(ADDR_CRC_CONTROL, 8'hC2);
    wr(ADDR_CRC_CONTROL, 8'h00);
    wr(ADDR_SCAN_CONTROL, 8'h9E);
    rchk(ADDR_SCAN_CONTROL, 8'h86);
    wr(ADDR_SCAN_CONTROL, 8'h00);
    $display("register access done");
    for (int k = 0; k < 4; k++) begin
      dl = 7 + $urandom % 9;
      pl = $urandom % 16;
      poly = 16'($urandom) | 16'h0001;
      sum_exp = 16'($urandom) & (16'hFFFF >> (15 - pl));
      wr(ADDR_CRC_WIDTHS, {4'(dl), 4'(pl)});
      wr(ADDR_TAPS_HIGH, poly[15:8]);
      wr(ADDR_TAPS_LOW, poly[7:0]);
      wr(ADDR_SUM_HIGH, sum_exp[15:8]);
      wr(ADDR_SUM_LOW, sum_exp[7:0]);
      wr(ADDR_CRC_CONTROL, {2'b11, 1'b0, k[0], 2'b00, k[1], 1'b0});
      for (int j = 0; j < 2; j++) begin
        w[j] = 16'($urandom);
        wr(ADDR_INPUT_HIGH, w[j][15:8]);
        wr(ADDR_INPUT_LOW, w[j][7:0]);
        sum_exp = crc_word(sum_exp, w[j], k[0], k[1]);
      end
      rchk(ADDR_CRC_CONTROL, {2'b11, 1'b1, k[0], 2'b00, k[1], 1'b1});
      poll(ADDR_CRC_CONTROL, CTL_BUSY, 1'b0);
      for (int z = 0; z <= pl; z++) begin
        if (k[0]) begin
          sum_exp = step(sum_exp, 1'b0, 1'b1);
        end
      end
      rchk(ADDR_SUM_HIGH, sum_exp[15:8]);
      rchk(ADDR_SUM_LOW, sum_exp[7:0]);
      rchk(ADDR_EVENTS, 8'h01);
      wr(ADDR_EVENTS, 8'h01);
      $display("cpu crc %0d done", k);
    end
    for (int m = 0; m < 3; m++) begin
      dl = 15;
      pl = 15;
      rg = 1'($urandom);
      poly = 16'($urandom) | 16'h0001;
      base = 22'($urandom) & 22'h00FFF0;
      nx = base + 22'h3;
      sum_exp = 16'h0000;
      wr(ADDR_EVENTS, 8'h03);
      wr(ADDR_CRC_WIDTHS, 8'hFF);
      wr(ADDR_TAPS_HIGH, poly[15:8]);
      wr(ADDR_TAPS_LOW, poly[7:0]);
      wr(ADDR_SUM_HIGH, 8'h00);
      wr(ADDR_SUM_LOW, 8'h00);
      wr(ADDR_CRC_CONTROL, 8'hC0);
      wr(ADDR_CUR_UPPER, 8'(base[21:16]));
      wr(ADDR_CUR_HIGH, base[15:8]);
      wr(ADDR_CUR_LOW, base[7:0]);
      wr(ADDR_END_UPPER, 8'(nx[21:16]));
      wr(ADDR_END_HIGH, nx[15:8]);
      wr(ADDR_END_LOW, nx[7:0]);
      slow <= m == 2;
      trig_rand <= m == 1;
      wr(ADDR_SCAN_CONTROL, {1'b1, m == 1, 1'b1, 2'b00, rg, m == 2, 1'b0});
      wr(ADDR_CUR_LOW, 8'hFF);
      poll(ADDR_EVENTS, EVT_SCAN_DONE, 1'b1);
      poll(ADDR_SCAN_CONTROL, SCN_RUN, 1'b0);
      poll(ADDR_CRC_CONTROL, CTL_BUSY, 1'b0);
      for (int i = 0; i < 4; i++) begin
        sum_exp = crc_word(sum_exp, mdata(base + 22'(i), rg), 1'b0, 1'b0);
      end
      rchk(ADDR_SUM_HIGH, sum_exp[15:8]);
      rchk(ADDR_SUM_LOW, sum_exp[7:0]);
      rchk(ADDR_SCAN_CONTROL, {1'b1, m == 1, 1'b0, 2'b00, rg, m == 2, 1'b0});
      nx = base + 22'h4;
      rchk(ADDR_CUR_UPPER, 8'(nx[21:16]));
      rchk(ADDR_CUR_HIGH, nx[15:8]);
      rchk(ADDR_CUR_LOW, nx[7:0]);
      $display("scan mode %0d done", m);
    end
    trig_rand <= 1'b0;
    wr(ADDR_END_UPPER, 8'h3F);
    wr(ADDR_SCAN_CONTROL, 8'hA2);
    repeat (20) @(posedge clk_sys);
    wr(ADDR_CRC_CONTROL, 8'h00);
    rd(ADDR_SCAN_CONTROL, rv);
    chk(24'(rv[SCN_RUN]), 24'h0);
    $display("crc disable stop done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
